/* rtl/lps_pkg.sv */
/*
 * Shared constants and carrier types for the panel power save sequencer.
 * Assumes a single 25 MHz system clock domain and a host front end that
 * has already decoded bus cycles into register and command strobes.
 */
package lps_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [15:0] LPS_PWR_SAVE_CTRL_OFS = 16'h0008;
	localparam int LPS_PSE_BIT = 0;         // Power save enable
	localparam int LPS_SLEEPING_BIT = 1;    // Read-only: low-power state reached
	localparam logic [7:0] LPS_PWR_SAVE_CTRL_RST = 8'h00;

	// ----------------------------------------------------------------
	// Sequencing counts
	// ----------------------------------------------------------------
	localparam int LPS_BLANK_FRAMES = 1;    // Whole blank frames before sleep
	localparam logic [1:0] LPS_BLANK_FRAMES_CNT = 2'(LPS_BLANK_FRAMES);

	// Sequencer states
	typedef enum logic [2:0] {
		LPS_RUN = 3'b000,
		LPS_WAIT_FRAME = 3'b001,
		LPS_BLANK = 3'b010,
		LPS_SLEEP = 3'b011,
		LPS_WAKE = 3'b100
	} lps_state_t;

	// Panel interface pin levels
	typedef struct packed {
		logic row_driver_disable;          // Low turns row driver bias off
		logic frame_pulse;
		logic row_shift_clock;
		logic ac_drive_inversion;
		logic line_pulse;
		logic column_enable_chain_clock;
		logic pixel_shift_clock;
		logic [3:0] panel_pixel_data;
		logic crystal_drive_out;
	} lps_panel_t;

	// Host side pins that must float while asleep
	typedef struct packed {
		logic [7:0] host_data_bus;
		logic host_data_oe;
		logic wait_n;
		logic wait_oe;
	} lps_host_pins_t;

	// Parked levels: everything low except row shift clock and crystal drive
	localparam lps_panel_t LPS_PANEL_PARKED = '{
		row_driver_disable: 1'b0,
		frame_pulse: 1'b0,
		row_shift_clock: 1'b1,
		ac_drive_inversion: 1'b0,
		line_pulse: 1'b0,
		column_enable_chain_clock: 1'b0,
		pixel_shift_clock: 1'b0,
		panel_pixel_data: 4'h0,
		crystal_drive_out: 1'b1
	};

	localparam lps_host_pins_t LPS_HOST_RELEASED = '{
		host_data_bus: 8'h00,
		host_data_oe: 1'b0,
		wait_n: 1'b1,
		wait_oe: 1'b0
	};

endpackage : lps_pkg

/* rtl/lps_power_save_ctrl.sv */
/*
 * Power save sequencer for a graphics panel controller: register bit and
 * indirect command entry, frame-aligned blanking, panel pin parking,
 * host bus release and internal clock halt.
 * Assumes register/command strobes, panel timing and host pin drives all
 * come from logic on clk_sys; frame_start pulses once per frame while the
 * panel timing runs.
 */
`timescale 1ns/100ps
`default_nettype none

module lps_power_save_ctrl #(
	parameter logic [7:0] CMD_SLEEP = 8'h53,    // Sleep command code
	parameter logic [7:0] CMD_SYS_SETUP = 8'h40 // System setup command code
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_byte,
	input wire logic display_on,
	input wire logic frame_start,
	input wire lps_pkg::lps_panel_t panel_in,
	input wire lps_pkg::lps_host_pins_t host_in,
	output lps_pkg::lps_panel_t panel_out,
	output lps_pkg::lps_host_pins_t host_out,
	output logic clocks_halted,
	output logic mem_ctrl_hold,
	output logic sleeping
);

	// ----------------------------------------------------------------
	// Register access and command decode
	// ----------------------------------------------------------------
	logic pse;
	logic next_pse;
	logic [7:0] next_reg_rdata;
	logic ctrl_wr;
	logic sleep_cmd;
	logic setup_cmd;

	assign ctrl_wr = reg_wr && (reg_addr == lps_pkg::LPS_PWR_SAVE_CTRL_OFS);
	assign sleep_cmd = cmd_valid && (cmd_byte == CMD_SLEEP);
	assign setup_cmd = cmd_valid && (cmd_byte == CMD_SYS_SETUP);

	// Enable bit; command strobes win over a same-cycle register write
	always_comb begin
		next_pse = pse;
		if (ctrl_wr) begin
			next_pse = reg_wdata[lps_pkg::LPS_PSE_BIT];
		end
		if (setup_cmd) begin
			next_pse = 1'b0;
		end
		if (sleep_cmd) begin
			next_pse = 1'b1;
		end
	end

	// Readback; unused bits read zero
	always_comb begin
		next_reg_rdata = reg_rdata;
		if (reg_rd) begin
			next_reg_rdata = 8'h00;
			if (reg_addr == lps_pkg::LPS_PWR_SAVE_CTRL_OFS) begin
				next_reg_rdata[lps_pkg::LPS_PSE_BIT] = pse;
				next_reg_rdata[lps_pkg::LPS_SLEEPING_BIT] = sleeping;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pse <= lps_pkg::LPS_PWR_SAVE_CTRL_RST[lps_pkg::LPS_PSE_BIT];
			reg_rdata <= 8'h00;
		end else begin
			pse <= next_pse;
			reg_rdata <= next_reg_rdata;
		end
	end

	// ----------------------------------------------------------------
	// Entry and exit sequencer
	// ----------------------------------------------------------------
	lps_pkg::lps_state_t state;
	lps_pkg::lps_state_t next_state;
	logic [1:0] frame_cnt;
	logic [1:0] next_frame_cnt;

	// A mid-frame request waits under one frame for the boundary, then
	// blanks one whole frame, so the disable line falls in 1..2 frames.
	always_comb begin
		next_state = state;
		next_frame_cnt = frame_cnt;
		case (state)
			lps_pkg::LPS_RUN: begin
				// boundary seen now
				// A boundary in the first enabled cycle must not be lost, or the
				// disable line would fall a cycle past the two-frame limit.
				if (pse && frame_start) begin
					next_state = lps_pkg::LPS_BLANK;
					next_frame_cnt = 2'd0;
				end else if (pse) begin
					next_state = lps_pkg::LPS_WAIT_FRAME;
				end
			end
			lps_pkg::LPS_WAIT_FRAME: begin
				if (!pse) begin
					next_state = lps_pkg::LPS_RUN;
				end else if (frame_start) begin
					next_state = lps_pkg::LPS_BLANK;
					next_frame_cnt = 2'd0;
				end
			end
			lps_pkg::LPS_BLANK: begin
				if (!pse) begin
					next_state = lps_pkg::LPS_RUN;
				end else if (frame_start) begin
					if (frame_cnt + 2'd1 >= lps_pkg::LPS_BLANK_FRAMES_CNT) begin
						next_state = lps_pkg::LPS_SLEEP;
					end else begin
						next_frame_cnt = frame_cnt + 2'd1;
					end
				end
			end
			lps_pkg::LPS_SLEEP: begin
				if (!pse) begin
					next_state = lps_pkg::LPS_WAKE;
				end
			end
			lps_pkg::LPS_WAKE: begin
				// One cycle here before re-arming; clocks and panel drive both resumed on entering WAKE
				next_state = pse ? lps_pkg::LPS_WAIT_FRAME : lps_pkg::LPS_RUN;
			end
			default: begin
				next_state = lps_pkg::LPS_RUN;
			end
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state <= lps_pkg::LPS_RUN;
			frame_cnt <= 2'd0;
		end else begin
			state <= next_state;
			frame_cnt <= next_frame_cnt;
		end
	end

	// ----------------------------------------------------------------
	// Pin steering
	// ----------------------------------------------------------------
	lps_pkg::lps_panel_t next_panel_out;
	lps_pkg::lps_host_pins_t next_host_out;
	logic next_clocks_halted;
	logic next_mem_ctrl_hold;
	logic next_sleeping;
	logic asleep;

	assign asleep = (next_state == lps_pkg::LPS_SLEEP);

	// Outputs follow next_state so pins and halt change together
	always_comb begin
		next_panel_out = panel_in;
		next_host_out = host_in;
		if (next_state == lps_pkg::LPS_BLANK) begin
			next_panel_out.panel_pixel_data = 4'h0;
		end
		if (asleep || !display_on) begin
			next_panel_out = lps_pkg::LPS_PANEL_PARKED;
			next_host_out = lps_pkg::LPS_HOST_RELEASED;
		end
		next_clocks_halted = asleep;
		next_mem_ctrl_hold = asleep;
		next_sleeping = asleep;
	end

	// Registers elsewhere are kept by the clock halt, not by reset
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			panel_out <= lps_pkg::LPS_PANEL_PARKED;
			host_out <= lps_pkg::LPS_HOST_RELEASED;
			clocks_halted <= 1'b0;
			mem_ctrl_hold <= 1'b0;
			sleeping <= 1'b0;
		end else begin
			panel_out <= next_panel_out;
			host_out <= next_host_out;
			clocks_halted <= next_clocks_halted;
			mem_ctrl_hold <= next_mem_ctrl_hold;
			sleeping <= next_sleeping;
		end
	end

endmodule : lps_power_save_ctrl

`default_nettype wire

/* dv/lps_power_save_ctrl_props.sv */
/* Port checker for the power save sequencer.
   Bound into every lps_power_save_ctrl instance below. */
`timescale 1ns/100ps
`default_nettype none
module lps_props #(
	parameter logic [7:0] CMD_SYS_SETUP = 8'h40 // Setup command code of the bound design
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic reg_wr,
	input wire logic [15:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_byte,
	input wire logic display_on,
	input wire logic frame_start,
	input wire lps_pkg::lps_panel_t panel_out,
	input wire lps_pkg::lps_host_pins_t host_out,
	input wire logic clocks_halted,
	input wire logic mem_ctrl_hold,
	input wire logic sleeping
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	// Asleep: parked pins, floating bus, stopped clocks, frozen memory
	a_sleep_parks: assert property (sleeping |-> panel_out == lps_pkg::LPS_PANEL_PARKED)
		else $error("pins not parked");
	a_bus_floats: assert property (sleeping |-> !host_out.host_data_oe && !host_out.wait_oe)
		else $error("bus driven");
	a_clocks_stop: assert property (sleeping |-> clocks_halted) else $error("clocks run");
	a_mem_held: assert property (sleeping |-> mem_ctrl_hold) else $error("memory free");
	// Outputs are registered, so display off shows one cycle later
	a_off_parks: assert property (!display_on |=> panel_out == lps_pkg::LPS_PANEL_PARKED)
		else $error("display off not parked");
	a_frame_edge: assert property ($rose(sleeping) |-> $past(frame_start)) else $error("off frame");
	// A clear by write or setup command wakes two cycles on
	a_write_wakes: assert property (
		sleeping && reg_wr && reg_addr == lps_pkg::LPS_PWR_SAVE_CTRL_OFS &&
		!reg_wdata[lps_pkg::LPS_PSE_BIT] && !cmd_valid |-> ##2 !sleeping)
		else $error("write did not wake");
	a_setup_wakes: assert property (sleeping && cmd_valid && cmd_byte == CMD_SYS_SETUP |-> ##2 !sleeping)
		else $error("setup did not wake");
	c_sleep: cover property ($rose(sleeping));
	c_wake: cover property ($fell(sleeping));
	c_off: cover property (!display_on);
endmodule : lps_props
bind lps_power_save_ctrl lps_props #(.CMD_SYS_SETUP(CMD_SYS_SETUP)) i_props (.clk_sys(clk_sys),
	.rst(rst), .reg_wr(reg_wr),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
	.display_on(display_on), .frame_start(frame_start), .panel_out(panel_out),
	.host_out(host_out), .clocks_halted(clocks_halted), .mem_ctrl_hold(mem_ctrl_hold),
	.sleeping(sleeping));
`default_nettype wire

/* dv/lps_panel_model.sv */
/* Panel timing stand-in: frame pulses and live panel pin levels.
   Runs off the bench clock and changes on falling edges. */
`timescale 1ns/100ps
`default_nettype none
module lps_panel_model #(
	parameter int FRAME = 20
) (
	input wire logic clk_sys,
	output logic frame_start = 1'h0,
	output lps_pkg::lps_panel_t panel_in = '0
);
	int cnt = 0;
	// Live levels oppose the parked ones and data is never zero
	always @(negedge clk_sys) begin
		cnt <= (cnt == FRAME - 1) ? 0 : cnt + 1;
		frame_start <= (cnt == FRAME - 1);
		panel_in <= {7'h6F, 4'(cnt) | 4'h1, 1'h0};
	end
endmodule : lps_panel_model
`default_nettype wire

/* dv/lps_power_save_ctrl_test.sv */
/* Self-checking bench for the power save sequencer.
   Uses the panel model for frames; the checker is bound in. */
`timescale 1ns/100ps
`default_nettype none
module lps_power_save_ctrl_test;
	typedef struct packed {logic c; logic [15:0] a; logic [7:0] d; logic [7:0] r;} lps_row_t;
	localparam int FRAME = 20;
	localparam logic [22:0] OFF_PINS = {lps_pkg::LPS_PANEL_PARKED, lps_pkg::LPS_HOST_RELEASED};
	logic clk_sys = 1'h0, rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, cmd_valid = 1'h0;
	logic display_on = 1'h1, frame_start, halted, hold, sleeping;
	logic [15:0] reg_addr = 16'h0008;
	logic [7:0] reg_wdata = 8'h00, reg_rdata;
	lps_pkg::lps_panel_t panel_in, panel_out;
	lps_pkg::lps_host_pins_t host_in = 11'h52D, host_out;
	int err_count = 0, check_count = 0, n, last;
	lps_row_t rows [6] = '{'{1'h0, 16'h8, 8'h1, 8'h1}, '{1'h0, 16'h8, 8'h0, 8'h0},
		'{1'h1, 16'h8, 8'h53, 8'h1}, '{1'h1, 16'h8, 8'h40, 8'h0},
		'{1'h0, 16'h9, 8'h1, 8'h0}, '{1'h1, 16'h8, 8'h59, 8'h0}};
	lps_power_save_ctrl i_dut (.clk_sys(clk_sys), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.cmd_valid(cmd_valid), .cmd_byte(reg_wdata), .display_on(display_on),
		.frame_start(frame_start), .panel_in(panel_in), .host_in(host_in),
		.panel_out(panel_out), .host_out(host_out), .clocks_halted(halted),
		.mem_ctrl_hold(hold), .sleeping(sleeping));
	lps_panel_model #(.FRAME(FRAME)) i_panel (.clk_sys(clk_sys), .frame_start(frame_start),
		.panel_in(panel_in));
	// 25 MHz system clock
	always #20 clk_sys = ~clk_sys;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// One strobe per call: 0 write, 1 command, 2 read
	task automatic op(input logic [1:0] k, input logic [15:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		reg_wr = (k == 2'h0);
		cmd_valid = (k == 2'h1);
		reg_rd = (k == 2'h2);
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk_sys);
		{reg_wr, cmd_valid, reg_rd} = 3'h0;
	endtask : op
	task automatic rd(input logic [7:0] e);
		op(2'h2, 16'h8, 8'h0);
		@(negedge clk_sys);
		chk(32'(reg_rdata), 32'(e));
	endtask : rd
	// Counts cycles to sleep and the last cycle that still had live data
	task automatic wait_sleep();
		n = 0;
		last = 0;
		while (sleeping !== 1'h1 && n < 100) begin
			@(negedge clk_sys);
			n++;
			if (panel_out.panel_pixel_data !== 4'h0) last = n;
		end
		if (sleeping !== 1'h1) begin
			err_count++;
			give_verdict();
		end
	endtask : wait_sleep
	task automatic give_verdict();
		$display("Checks %0d, mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : give_verdict
	// Table cases, then entry, exits, display off and a reset while asleep
	initial begin
		repeat (10) @(negedge clk_sys);
		rst = 1'h0;
		foreach (rows[i]) begin
			op({1'h0, rows[i].c}, rows[i].a, rows[i].d);
			rd(rows[i].r);
		end
		op(2'h0, 16'h8, 8'h1);
		wait_sleep();
		chk(32'(n >= FRAME && n <= 2 * FRAME), 32'h1);
		chk(32'(n - last >= FRAME - 1), 32'h1);
		chk(32'({panel_out, host_out}), 32'(OFF_PINS));
		chk(32'({halted, hold}), 32'h3);
		rd(8'h3);
		op(2'h0, 16'h8, 8'h0);
		op(2'h0, 16'h8, 8'h0);
		chk(32'({sleeping, panel_out.row_driver_disable, host_out}), 32'hD2D);
		op(2'h1, 16'h8, 8'h53);
		wait_sleep();
		chk(32'(n >= FRAME && n <= 2 * FRAME), 32'h1);
		op(2'h1, 16'h8, 8'h40);
		op(2'h0, 16'h8, 8'h0);
		op(2'h0, 16'h8, 8'h0);
		chk(32'({sleeping, halted, hold}), 32'h0);
		display_on = 1'h0;
		repeat (2) @(negedge clk_sys);
		chk(32'({panel_out, host_out}), 32'(OFF_PINS));
		display_on = 1'h1;
		op(2'h0, 16'h8, 8'h1);
		wait_sleep();
		rst = 1'h1;
		@(negedge clk_sys);
		rst = 1'h0;
		chk(32'({sleeping, halted}), 32'h0);
		rd(8'h0);
		give_verdict();
	end
endmodule : lps_power_save_ctrl_test
`default_nettype wire
